// ==== core/smb_ctrl.sv ====
// Purpose: two-wire serial bus controller, control and clock rate logic
// Assumes: open-drain pins resolved outside; pins asynchronous to clk
// Notes:   registers on the special function register port
// Summary of operation
// - enable bit set makes the interface active on the bus
// - enable bit clear disables interface and releases both lines
// - toggling enable off and on aborts transfer, drops bus state
// - start request bit makes the interface a master
// - start request with free bus generates a START
// - busy bus: wait for STOP, then START after one rate period
// - bus idle for the free time counts as free without STOP
// - start request as master after a byte gives repeated START
// - stop request as master drives a STOP onto the bus
// - stop request as slave acts as received STOP, unaddressed
// - hardware clears stop request when a STOP is seen
// - hardware sets serial interrupt flag on each new status code except CODE_IDLE
// - only software clears the serial interrupt flag
// - flag set with interrupt enabled raises an interrupt request
// - while the flag is set in the hold state, SCL is held low
// - acknowledge bit set drives SDA low in ack clock when addressed
// - acknowledge bit clear leaves SDA high in ack clock
// - acknowledge bit clear ignores own and general call address
// - free timer: lines high for rate-based timeout free the bus
// - timeout enable gates external timer count while SCL low
module smb_ctrl
  import smb_pkg::*;
#(
  parameter int P_FREE_CYC = FREE_CYC
)
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       int_en,
  output logic            irq,
  output logic            tmr3_gate,
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe
);

  // ==========================================================================
  // registers
  logic       ens_ff, sta_ff, sto_ff, si_ff, aa_ff, fte_ff, toe_ff;
  logic [7:0] rate_ff, data_ff, own_ff, code_ff, rdata_ff;
  smb_state_e st_ff, nxt_st;
  logic       master_ff, nxt_master, addr_ff, nxt_addr, tx_ff, nxt_tx;
  logic       done_ff, nxt_done, first_ff, nxt_first, busy_ff, nxt_busy;
  logic       sclo_ff, nxt_sclo, sdao_ff, nxt_sdao, ack_ff, nxt_ack;
  logic       gack_ff, nxt_gack, txb_ff, nxt_txb;
  logic [3:0] cnt_ff, nxt_cnt, fcnt_ff;
  logic [7:0] nxt_data, nxt_code;
  logic [12:0] idle_ff;
  logic       si_set, sto_clr, tick;
  logic       scl_m_ff, scl_s_ff, scl_p_ff, sda_m_ff, sda_s_ff, sda_p_ff;

  // ==========================================================================
  // bus events from the synchronised lines
  wire scl_rise  = scl_s_ff && !scl_p_ff;
  wire scl_fall  = !scl_s_ff && scl_p_ff;
  wire start_det = scl_s_ff && scl_p_ff && sda_p_ff && !sda_s_ff;
  wire stop_det  = scl_s_ff && scl_p_ff && !sda_p_ff && sda_s_ff;
  wire lines_hi  = scl_s_ff && sda_s_ff;
  wire free_hit  = fte_ff && tick && (fcnt_ff == FREE_TICKS);
  wire idle_hit  = (idle_ff == 13'(P_FREE_CYC));
  wire adr_match = aa_ff && ((data_ff[7:1] == own_ff[7:1]) ||
                   ((data_ff[7:1] == 7'h00) && own_ff[0]));

  // register decode
  wire wr_ctl  = sfr_wr && (sfr_addr == ADDR_CTL);
  wire wr_data = sfr_wr && (sfr_addr == ADDR_DATA);
  wire wr_own  = sfr_wr && (sfr_addr == ADDR_OWN);
  wire wr_rate = sfr_wr && (sfr_addr == ADDR_RATE);
  wire [7:0] ctl_rd = {busy_ff, ens_ff, sta_ff, sto_ff, si_ff, aa_ff, fte_ff, toe_ff};
  wire [7:0] rd_mux = (sfr_addr == ADDR_CTL)  ? ctl_rd  :
                      (sfr_addr == ADDR_STAT) ? code_ff :
                      (sfr_addr == ADDR_DATA) ? data_ff :
                      (sfr_addr == ADDR_OWN)  ? own_ff  :
                      (sfr_addr == ADDR_RATE) ? rate_ff : 8'h00;

  // ==========================================================================
  // pin drive: open drain, enable high pulls the line low
  wire scl_pull = ens_ff && (sclo_ff || (si_ff && st_ff == SMB_HOLD));
  wire sda_pull = ens_ff && (sdao_ff || ack_ff ||
                  (st_ff == SMB_XFER && cnt_ff < BIT_ACK && tx_ff && !txb_ff));
  assign scl_o     = 1'b0;
  assign sda_o     = 1'b0;
  assign scl_oe    = scl_pull;
  assign sda_oe    = sda_pull;
  assign irq       = si_ff && int_en;
  assign tmr3_gate = ens_ff && toe_ff && !scl_s_ff;
  assign sfr_rdata = rdata_ff;

  // rate counter: each rollover ends one SCL phase
  smb_rate_tmr u_rate (
    .clk     (clk),
    .nrst    (nrst),
    .ce      (ce),
    .run     (ens_ff),
    .load    (stop_det),
    .preload (rate_ff),
    .tick    (tick)
  );

  // ==========================================================================
  // protocol engine next state
  always_comb begin
    nxt_st = st_ff;   nxt_master = master_ff; nxt_addr = addr_ff;
    nxt_tx = tx_ff;   nxt_done = done_ff;     nxt_first = first_ff;
    nxt_sclo = sclo_ff; nxt_sdao = sdao_ff;   nxt_ack = ack_ff;
    nxt_gack = gack_ff; nxt_txb = txb_ff;     nxt_cnt = cnt_ff;
    nxt_data = wr_data ? sfr_wdata : data_ff;
    nxt_code = code_ff; si_set = 1'b0;        sto_clr = stop_det;
    nxt_busy = (busy_ff || start_det) && !stop_det && !free_hit && !idle_hit;
    if (!ens_ff) begin
      nxt_st = SMB_IDLE; nxt_master = 1'b0; nxt_addr = 1'b0; nxt_busy = 1'b0;
      nxt_sclo = 1'b0;   nxt_sdao = 1'b0;   nxt_ack = 1'b0;  nxt_code = CODE_IDLE;
    end else begin
      case (st_ff)
        SMB_IDLE: begin
          nxt_sclo = 1'b0;
          nxt_sdao = 1'b0;
          if (sta_ff && !busy_ff && !start_det && tick) begin
            nxt_st = SMB_START; nxt_master = 1'b1; nxt_sdao = 1'b1;
            nxt_done = 1'b0;
          end else if (start_det) begin
            nxt_st = SMB_XFER; nxt_cnt = 4'h0; nxt_tx = 1'b0; nxt_addr = 1'b0;
            nxt_first = 1'b1;                                             // address byte next
          end
        end
        SMB_START: begin
          if (tick) begin
            nxt_sclo = 1'b1; nxt_st = SMB_HOLD; nxt_tx = 1'b1; nxt_first = 1'b1;
            si_set = 1'b1;
            nxt_code = done_ff ? CODE_RSTART : CODE_START;
          end
        end
        SMB_HOLD: begin
          if (!master_ff && stop_det) begin
            nxt_st = SMB_IDLE; nxt_addr = 1'b0;
          end else if (!si_ff) begin
            nxt_txb = data_ff[7];
            nxt_ack = 1'b0;
            if (sto_ff && master_ff) begin
              nxt_st = SMB_STOP; nxt_sdao = 1'b1;
            end else if (sto_ff) begin
              nxt_st = SMB_IDLE; nxt_addr = 1'b0; sto_clr = 1'b1;
            end else if (sta_ff && master_ff && done_ff) begin
              nxt_st = SMB_RSTART; nxt_sdao = 1'b0;
            end else begin
              nxt_st = SMB_XFER; nxt_cnt = 4'h0; nxt_sdao = 1'b0;
            end
          end
        end
        SMB_XFER: begin
          if (master_ff && tick) begin
            if (sclo_ff) nxt_sclo = 1'b0;
            else if (scl_s_ff) nxt_sclo = 1'b1;
          end
          if (!master_ff && stop_det) begin
            nxt_st = SMB_IDLE;
            nxt_ack = 1'b0;
            if (addr_ff) begin
              si_set = 1'b1; nxt_code = CODE_S_STOP;
            end
            nxt_addr = 1'b0;
          end else if (!master_ff && start_det) begin
            nxt_cnt = 4'h0; nxt_addr = 1'b0; nxt_tx = 1'b0; nxt_ack = 1'b0;
            nxt_first = 1'b1;                                             // address byte next
          end else if (scl_rise) begin
            if (cnt_ff < BIT_ACK) nxt_data = {data_ff[6:0], sda_s_ff};
            else nxt_gack = !sda_s_ff;
            nxt_cnt = cnt_ff + 4'h1;
          end else if (scl_fall && cnt_ff == BIT_ACK) begin
            if (!master_ff && !addr_ff) begin
              if (adr_match) begin
                nxt_addr = 1'b1; nxt_ack = 1'b1;
              end else begin
                nxt_st = SMB_IDLE;
              end
            end else begin
              nxt_ack = !tx_ff && aa_ff;
            end
          end else if (scl_fall && cnt_ff == BIT_END) begin
            nxt_ack = 1'b0; nxt_st = SMB_HOLD; si_set = 1'b1;
            if (master_ff) begin
              nxt_done = 1'b1; nxt_first = 1'b0; nxt_sclo = 1'b1;
              nxt_code = gack_ff ? CODE_M_ACK : CODE_M_NACK;
              if (first_ff) nxt_tx = !data_ff[0];
            end else if (first_ff) begin
              // first byte after a START is our own or the general call address
              nxt_code = CODE_S_ADR;
              nxt_first = 1'b0;
            end else if (!tx_ff) begin
              nxt_code = CODE_S_RX;
            end else begin
              nxt_code = gack_ff ? CODE_S_TXA : CODE_S_TXN;
            end
          end else if (scl_fall && cnt_ff < BIT_ACK) begin
            nxt_txb = data_ff[7];
          end
          if (scl_fall && cnt_ff == BIT_ACK && !master_ff && !addr_ff && adr_match) begin
            nxt_tx = data_ff[0];
          end
        end
        SMB_STOP: begin
          if (tick && sclo_ff) nxt_sclo = 1'b0;
          else if (tick && scl_s_ff) begin
            nxt_sdao = 1'b0; nxt_master = 1'b0; nxt_st = SMB_IDLE;
          end
        end
        SMB_RSTART: begin
          if (tick && sclo_ff) nxt_sclo = 1'b0;
          else if (tick && scl_s_ff) begin
            nxt_sdao = 1'b1; nxt_st = SMB_START;
          end
        end
        default: nxt_st = SMB_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // pin synchronisers and edge history
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {scl_m_ff, scl_s_ff, scl_p_ff} <= 3'b111;
      {sda_m_ff, sda_s_ff, sda_p_ff} <= 3'b111;
    end else if (ce) begin
      {scl_m_ff, scl_s_ff, scl_p_ff} <= {scl_i, scl_m_ff, scl_s_ff};
      {sda_m_ff, sda_s_ff, sda_p_ff} <= {sda_i, sda_m_ff, sda_s_ff};
    end
  end

  // bus free counters: rate ticks for the free timer, cycles for idle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fcnt_ff <= 4'h0;
      idle_ff <= 13'h0000;
    end else if (ce) begin
      fcnt_ff <= !lines_hi ? 4'h0 : (tick && fcnt_ff != FREE_TICKS) ? fcnt_ff + 4'h1 : fcnt_ff;
      idle_ff <= (!lines_hi || idle_hit) ? 13'h0000 : idle_ff + 13'h0001;
    end
  end

  // control register: hardware set of the flag wins over software clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {ens_ff, sta_ff, sto_ff, si_ff, aa_ff, fte_ff, toe_ff} <= 7'h00;
    end else if (ce) begin
      if (wr_ctl) begin
        {ens_ff, sta_ff, aa_ff, fte_ff, toe_ff} <= {sfr_wdata[CTL_ENS], sfr_wdata[CTL_STA],
          sfr_wdata[CTL_AA], sfr_wdata[CTL_FTE], sfr_wdata[CTL_TOE]};
      end
      sto_ff <= wr_ctl ? sfr_wdata[CTL_STO] : (sto_ff && !sto_clr);
      si_ff  <= si_set || (wr_ctl ? sfr_wdata[CTL_SI] : si_ff);
    end
  end

  // data, address, rate, status and read data registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_ff  <= RST_DATA;
      own_ff   <= RST_OWN;
      rate_ff  <= RST_RATE;
      code_ff  <= CODE_IDLE;
      rdata_ff <= 8'h00;
    end else if (ce) begin
      data_ff <= nxt_data;
      code_ff <= nxt_code;
      if (wr_own) own_ff <= sfr_wdata;
      if (wr_rate) rate_ff <= sfr_wdata;
      if (sfr_rd) rdata_ff <= rd_mux;
    end
  end

  // protocol engine state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= SMB_IDLE;
      {master_ff, addr_ff, tx_ff, done_ff, first_ff, busy_ff} <= 6'h00;
      {sclo_ff, sdao_ff, ack_ff, gack_ff, txb_ff} <= 5'h1F & 5'h01;
      cnt_ff <= 4'h0;
    end else if (ce) begin
      st_ff <= nxt_st;
      {master_ff, addr_ff, tx_ff, done_ff, first_ff, busy_ff} <=
        {nxt_master, nxt_addr, nxt_tx, nxt_done, nxt_first, nxt_busy};
      {sclo_ff, sdao_ff, ack_ff, gack_ff, txb_ff} <= {nxt_sclo, nxt_sdao, nxt_ack, nxt_gack, nxt_txb};
      cnt_ff <= nxt_cnt;
    end
  end

endmodule // smb_ctrl

// ==== core/smb_pkg.sv ====
// Purpose: shared constants and types of the serial bus controller
// Assumes: registers sit on the special function register port
// Notes:   all offsets, field positions and counts live here
package smb_pkg;

  // ==========================================================================
  // register offsets on the special function register port
  localparam logic [7:0] ADDR_CTL  = 8'hC0;
  localparam logic [7:0] ADDR_STAT = 8'hC1;
  localparam logic [7:0] ADDR_DATA = 8'hC2;
  localparam logic [7:0] ADDR_OWN  = 8'hC3;
  localparam logic [7:0] ADDR_RATE = 8'hCF;

  // ==========================================================================
  // control register field positions
  localparam int CTL_BUSY = 7;
  localparam int CTL_ENS  = 6;
  localparam int CTL_STA  = 5;
  localparam int CTL_STO  = 4;
  localparam int CTL_SI   = 3;
  localparam int CTL_AA   = 2;
  localparam int CTL_FTE  = 1;
  localparam int CTL_TOE  = 0;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_RATE = 8'h00;
  localparam logic [7:0] RST_OWN  = 8'h00;
  localparam logic [7:0] RST_DATA = 8'h00;

  // ==========================================================================
  // status codes reported with each serial interrupt
  localparam logic [7:0] CODE_IDLE   = 8'hF8;
  localparam logic [7:0] CODE_START  = 8'h08;
  localparam logic [7:0] CODE_RSTART = 8'h10;
  localparam logic [7:0] CODE_M_ACK  = 8'h18;
  localparam logic [7:0] CODE_M_NACK = 8'h20;
  localparam logic [7:0] CODE_S_ADR  = 8'h60;
  localparam logic [7:0] CODE_S_RX   = 8'h80;
  localparam logic [7:0] CODE_S_STOP = 8'hA0;
  localparam logic [7:0] CODE_S_TXA  = 8'hB8;
  localparam logic [7:0] CODE_S_TXN  = 8'hC0;

  // ==========================================================================
  // bit counter marks and timing
  localparam logic [3:0] BIT_ACK    = 4'h8;
  localparam logic [3:0] BIT_END    = 4'h9;
  localparam logic [3:0] FREE_TICKS = 4'hA;
  localparam int         CLK_MHZ    = 100;
  localparam int         FREE_US    = 50;
  localparam int         FREE_CYC   = FREE_US * CLK_MHZ;

  // engine states, gray steps along the usual path
  typedef enum logic [2:0] {
    SMB_IDLE   = 3'b000,
    SMB_START  = 3'b001,
    SMB_HOLD   = 3'b011,
    SMB_XFER   = 3'b010,
    SMB_STOP   = 3'b110,
    SMB_RSTART = 3'b111
  } smb_state_e;

endpackage

// ==== core/smb_rate_tmr.sv ====
// Purpose: 8-bit up-counter preloaded from the clock rate register
// Assumes: same clock as the controller
// Notes:   tick pulses one cycle on each rollover from 8'hFF, which reloads the preload
module smb_rate_tmr
  import smb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic       load,
  input  wire logic [7:0] preload,
  output logic            tick
);

  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  wire        roll = run && (cnt_ff == 8'hFF);

  // ==========================================================================
  // counter: reload on rollover or restart
  assign nxt_cnt = (!run || load || roll) ? preload : cnt_ff + 8'h01;
  assign tick    = roll;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= 8'h00;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule // smb_rate_tmr

// ==== dv/smb_chk.sv ====
// Purpose: port-level assertions for the serial bus controller
// Assumes: one clock domain, nrst asynchronous and active low
// Notes:   bound to smb_ctrl from the testbench top file
module smb_chk
  import smb_pkg::*;
(
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       ce,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       int_en,
  input wire logic       irq,
  input wire logic       tmr3_gate,
  input wire logic       scl_i,
  input wire logic       scl_o,
  input wire logic       scl_oe,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========================================================================
  // decodes and a mirror of the rate register
  logic [7:0] rate_ff;
  wire        rd_hit = ce && sfr_rd;
  wire        ctl_wr = ce && sfr_wr && sfr_addr == ADDR_CTL;
  wire        mapped = sfr_addr inside {ADDR_CTL, ADDR_STAT, ADDR_DATA, ADDR_OWN, ADDR_RATE};
  // mirror follows every taken rate write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rate_ff <= RST_RATE;
    end else if (ce && sfr_wr && sfr_addr == ADDR_RATE) begin
      rate_ff <= sfr_wdata;
    end
  end
  // disable write followed by a quiet cycle
  sequence s_off_wr;
    ctl_wr && !sfr_wdata[CTL_ENS] ##1 !ctl_wr;
  endsequence
  // flag up and no software clear this cycle
  sequence s_si_held;
    irq && !(ctl_wr && !sfr_wdata[CTL_SI]);
  endsequence
  // ==========================================================================
  // assertions
  chk_irq_gated: assert property (irq |-> int_en)
    else $error("irq high while interrupt disabled");
  chk_off_release: assert property (s_off_wr |=> !scl_oe && !sda_oe)
    else $error("bus lines not released after disable");
  chk_si_sticky: assert property (s_si_held |=> irq || !int_en)
    else $error("flag dropped without software clear");
  chk_scl_stretch: assert property (irq && scl_oe |=> scl_oe || !irq)
    else $error("clock released while flag set");
  chk_gate_scl_low: assert property (tmr3_gate |-> !$past(scl_i, 2) || !$past(scl_i, 3))
    else $error("timer gate open while clock high");
  chk_rate_readback: assert property (rd_hit && sfr_addr == ADDR_RATE |=> sfr_rdata == rate_ff)
    else $error("rate register read mismatch");
  chk_unmapped_zero: assert property (rd_hit && !mapped |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!rd_hit |=> $stable(sfr_rdata))
    else $error("read data changed without read");
  chk_open_drain: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("open drain output driven high");
endmodule // smb_chk

// ==== dv/smb_peer.sv ====
// Purpose: behavioural far-side master on the two-wire bus
// Assumes: lines are open drain, pull-ups resolved in tb
// Notes:   160 ns bit clock, stretching honoured with a bounded wait
module smb_peer (
  input wire logic scl,
  input wire logic sda,
  output logic     scl_pull,
  output logic     sda_pull
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // lines released at start
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  // one clock: data set while low, sampled mid-high, clock left low
  task automatic clk_bit(input logic b, inout logic ok, output logic s);
    #40;
    sda_pull = ~b;
    #40;
    scl_pull = 1'b0;
    for (int n = 0; n < 5000 && scl !== 1'b1; n++) #10;
    ok = ok & (scl === 1'b1);
    #40;
    s = sda;
    #40;
    scl_pull = 1'b1;
  endtask
  // start, address byte msb first, then the acknowledge slot
  task automatic send(input logic [7:0] b, output logic ack, output logic ok);
    ok = 1'b1;
    sda_pull = 1'b1;
    #80;
    scl_pull = 1'b1;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], ok, ack);
    clk_bit(1'b1, ok, ack);
    ack = ~ack;
  endtask
  // stop: SDA rises while SCL high, then both stay released
  task automatic stop(output logic ok);
    #40;
    sda_pull = 1'b1;
    #40;
    scl_pull = 1'b0;
    for (int n = 0; n < 5000 && scl !== 1'b1; n++) #10;
    ok = (scl === 1'b1);
    #80;
    sda_pull = 1'b0;
    #80;
  endtask
  // hold the clock low for the timeout gate
  task automatic hold(input logic v);
    scl_pull = v;
  endtask
endmodule // smb_peer

// ==== dv/tb.sv ====
// Purpose: self-checking bench for the serial bus controller
// Assumes: far side is the behavioural peer master
// Notes:   read results noted in a queue and compared by a monitor
module tb
  import smb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] exp; logic [7:0] msk; string nm;} smb_note_s;
  logic clk, nrst, ce, sfr_wr, sfr_rd, int_en, irq, tmr3_gate;
  logic scl_o, scl_oe, sda_o, sda_oe, p_scl, p_sda, ack, ok, rd_d;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rate, rv;
  int n_fail, n_compared, seed, r;
  smb_note_s q[$];
  wire scl = ~(scl_oe | p_scl);
  wire sda = ~(sda_oe | p_sda);
  // ==========================================================================
  // design, peer and clock
  smb_ctrl #(.P_FREE_CYC(50)) dut (.clk(clk), .nrst(nrst), .ce(ce), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .int_en(int_en), .irq(irq), .tmr3_gate(tmr3_gate), .scl_i(scl), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
  smb_peer peer (.scl(scl), .sda(sda), .scl_pull(p_scl), .sda_pull(p_sda));
  always #5 clk = ~clk;
  // ==========================================================================
  // compare, bus and report tasks
  task automatic cmp(string nm, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic pin(string nm, logic exp, logic got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, string nm, logic [7:0] exp, logic [7:0] msk);
    q.push_back('{exp, msk, nm});
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    rv = sfr_rdata;
  endtask
  task automatic results();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // bounded poll of one control bit
  task automatic wait_ctl(int b, logic v, string nm);
    rv = {8{~v}};
    for (int n = 0; n < 3000 && rv[b] !== v; n++) rd(ADDR_CTL, nm, 8'h00, 8'h00);
    if (rv[b] !== v) begin
      n_fail++;
      $display("CHECK FAILED %s expected %b seen %b", nm, v, rv[b]);
      results();
    end
  endtask
  // ==========================================================================
  // monitor: oldest note against each read result
  always @(posedge clk) rd_d <= sfr_rd;
  always @(negedge clk) begin : mon
    smb_note_s n;
    if (rd_d && q.size() > 0) begin
      n = q.pop_front();
      if (n.msk != 8'h00) cmp(n.nm, n.exp & n.msk, sfr_rdata & n.msk);
    end
  end
  // ==========================================================================
  // main sequence
  initial begin
    {clk, nrst, sfr_wr, sfr_rd, int_en, sfr_addr, sfr_wdata} = '0;
    ce = 1'b1;
    seed = 78610;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    r = $random(seed);
    rate = {4'hF, r[3:0]};
    rd(ADDR_RATE, "rate_reset", RST_RATE, 8'hFF);
    rd(8'h55, "unmapped", 8'h00, 8'hFF);
    wr(ADDR_RATE, rate);
    rd(ADDR_RATE, "rate_rw", rate, 8'hFF);
    $display("test registers done");
    wr(ADDR_CTL, 8'h60);
    wait_ctl(CTL_SI, 1'b1, "si_start");
    pin("irq_masked", 1'b0, irq);
    int_en = 1'b1;
    @(negedge clk);
    pin("irq", 1'b1, irq);
    pin("sda_start", 1'b1, sda_oe);
    rd(ADDR_STAT, "st_start", CODE_START, 8'hFF);
    repeat (40) @(negedge clk);
    pin("scl_held", 1'b1, scl_oe);
    rd(ADDR_CTL, "si_kept", 8'h08, 8'h08);
    wr(ADDR_DATA, r[11:4]);
    wr(ADDR_CTL, 8'h40);
    wait_ctl(CTL_SI, 1'b1, "si_byte");
    rd(ADDR_STAT, "st_nack", CODE_M_NACK, 8'hFF);
    wr(ADDR_CTL, 8'h60);
    wait_ctl(CTL_SI, 1'b1, "si_rstart");
    rd(ADDR_STAT, "st_rstart", CODE_RSTART, 8'hFF);
    wr(ADDR_CTL, 8'h54);
    wait_ctl(CTL_STO, 1'b0, "sto_clear");
    repeat (40) @(negedge clk);
    pin("scl_rel", 1'b0, scl_oe);
    pin("sda_rel", 1'b0, sda_oe);
    $display("test master done");
    wr(ADDR_OWN, 8'hA5);
    peer.send(8'h30, ack, ok);
    wr(ADDR_CTL, 8'h64);
    repeat (60) @(negedge clk);
    pin("no_start_busy", 1'b0, sda_oe);
    peer.stop(ok);
    wait_ctl(CTL_SI, 1'b1, "si_after_stop");
    rd(ADDR_STAT, "st_busy", CODE_START, 8'hFF);
    wr(ADDR_CTL, 8'h54);
    wait_ctl(CTL_STO, 1'b0, "sto_busy");
    $display("test busy bus done");
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CTL, k[1] ? 8'h44 : 8'h40);
      peer.send(k[0] ? 8'h00 : 8'hA4, ack, ok);
      pin("ack", k[1], ack);
      repeat (20) @(negedge clk);
      rd(ADDR_CTL, "si_addr", {4'h0, k[1], 3'h0}, 8'h08);
      pin("scl_str", k[1], scl_oe);
      if (k == 2) rd(ADDR_STAT, "st_addr", CODE_S_ADR, 8'hFF);
      wr(ADDR_CTL, k == 3 ? 8'h54 : {5'h08, k[1], 2'h0});
      repeat (20) @(negedge clk);
      pin("no_stop_drive", 1'b0, sda_oe);
      peer.stop(ok);
      pin("bus_free", 1'b1, ok);
      repeat (20) @(negedge clk);
      rd(ADDR_CTL, "si_stop", {3'h0, 1'b0, k == 2, 3'h0}, 8'h18);
    end
    $display("test slave done");
    wr(ADDR_CTL, 8'h41);
    peer.hold(1'b1);
    repeat (5) @(negedge clk);
    pin("gate_low", 1'b1, tmr3_gate);
    peer.hold(1'b0);
    repeat (5) @(negedge clk);
    pin("gate_high", 1'b0, tmr3_gate);
    wr(ADDR_CTL, 8'h40);
    peer.hold(1'b1);
    repeat (5) @(negedge clk);
    pin("gate_off", 1'b0, tmr3_gate);
    peer.hold(1'b0);
    $display("test timeout gate done");
    wr(ADDR_CTL, 8'h60);
    wait_ctl(CTL_SI, 1'b1, "si_again");
    wr(ADDR_CTL, 8'h00);
    repeat (3) @(negedge clk);
    pin("scl_off", 1'b0, scl_oe);
    pin("sda_off", 1'b0, sda_oe);
    wr(ADDR_CTL, 8'h40);
    rd(ADDR_STAT, "st_abort", CODE_IDLE, 8'hFF);
    repeat (40) @(negedge clk);
    pin("no_restart", 1'b0, sda_oe);
    $display("test disable done");
    results();
  end
endmodule // tb

bind smb_ctrl smb_chk chk (.clk(clk), .nrst(nrst), .ce(ce), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .int_en(int_en), .irq(irq), .tmr3_gate(tmr3_gate), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));
